// ===== dwh_pin_sync.sv
// two flip-flop synchroniser for the debug pin
`default_nettype none
module dwh_pin_sync
    import dwh_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_async,
    output logic pin_sync
);
    typedef struct packed {
        logic meta;
        logic stable;
    } dwh_sync_t;

    dwh_sync_t s_reg;
    dwh_sync_t s_next;

    // first stage feeds only the second stage
    always_comb begin
        s_next.meta = pin_async;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= {PIN_IDLE, PIN_IDLE};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pin_sync = s_reg.stable;
endmodule : dwh_pin_sync
`default_nettype wire

// ===== dwh_pkg.sv
// shared constants and types of the debug wire handshake block
`default_nettype none
package dwh_pkg;
    // core clock and serial clock relation
    localparam int CLK_PERIOD_NS = 10;
    localparam int SER_DIV = 8;
    localparam int SER_DIV_W = 3;
    localparam logic [SER_DIV_W-1:0] SER_DIV_LAST = 3'h7;
    // counters in serial clock cycles
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] SYNC_THRESH_TICKS = 10'h080;
    localparam logic [CNT_W-1:0] SYNC_DELAY_TICKS = 10'h010;
    localparam logic [CNT_W-1:0] SYNC_LOW_TICKS = 10'h080;
    localparam logic [CNT_W-1:0] ACK_LOW_TICKS = 10'h010;
    localparam logic [CNT_W-1:0] TIMEOUT_TICKS = 10'h200;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    // idle level of the open-drain pin
    localparam logic PIN_IDLE = 1'b1;

    // command classes handed in by the command decoder
    typedef enum logic [2:0] {
        KIND_READ = 3'h0,
        KIND_WRITE = 3'h1,
        KIND_HALT = 3'h2,
        KIND_RESUME = 3'h3,
        KIND_RUN_HALT = 3'h4,
        KIND_STEP = 3'h5,
        KIND_ACK_EN = 3'h6,
        KIND_ACK_DIS = 3'h7
    } dwh_kind_t;

    // pin level state machine, one-hot
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_LOW_MEAS = 8'h02,
        ST_WAIT_HIGH = 8'h04,
        ST_SYNC_DELAY = 8'h08,
        ST_SYNC_LOW = 8'h10,
        ST_SYNC_SPEED = 8'h20,
        ST_ACK_LOW = 8'h40,
        ST_ACK_SPEED = 8'h80
    } dwh_state_t;
endpackage : dwh_pkg
`default_nettype wire

// ===== dwh_probe.sv
// debug probe model: drives the open-drain pin and times the target's low pulses
`default_nettype none
module dwh_probe (
    input wire logic clk,
    input wire logic pin,
    output logic drv_low,
    output logic drv_high,
    output int low_len
);
    timeunit 1ns;
    timeprecision 1ps;
    int run_len;
    initial begin
        drv_low = 1'b0;
        drv_high = 1'b0;
        low_len = 0;
        run_len = 0;
    end
    // low time of target pulses gives the target serial rate
    always @(posedge clk) begin
        if (!pin && !drv_low) begin
            run_len++;
        end else if (run_len != 0) begin
            low_len = run_len;
            run_len = 0;
        end
    end
    // n core cycles low, one serial cycle speedup, then release
    task automatic pulse(input int n);
        @(negedge clk);
        drv_low = 1'b1;
        repeat (n) @(negedge clk);
        drv_low = 1'b0;
        drv_high = 1'b1;
        repeat (8) @(negedge clk);
        drv_high = 1'b0;
    endtask : pulse
endmodule : dwh_probe
`default_nettype wire

// ===== dwh_ser_div.sv
// serial clock tick: one core cycle in every eight
`default_nettype none
module dwh_ser_div
    import dwh_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    typedef struct packed {
        logic [SER_DIV_W-1:0] cnt;
        logic tick;
    } dwh_div_t;

    dwh_div_t d_reg;
    dwh_div_t d_next;

    always_comb begin
        d_next.cnt = d_reg.cnt + {{(SER_DIV_W-1){1'b0}}, 1'b1};
        d_next.tick = (d_reg.cnt == SER_DIV_LAST);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            d_reg <= '0;
        end else begin
            d_reg <= d_next;
        end
    end

    assign tick = d_reg.tick;
endmodule : dwh_ser_div
`default_nettype wire

// ===== dwh_top.sv
// debug wire handshake: acknowledge pulses, abort and timed reference
`default_nettype none
module dwh_top
    import dwh_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic debug_serial_pin_in,
    output logic debug_serial_pin_out,
    output logic debug_serial_pin_oe_n,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_kind,
    input wire logic mem_busy,
    input wire logic mem_done,
    input wire logic cpu_enter_bg,
    input wire logic cpu_exit_bg,
    input wire logic xfer_partial,
    output logic abort_cmd,
    output logic soft_reset,
    output logic bit_start,
    output logic sync_seen,
    output logic ack_sent,
    output logic ack_enabled,
    output logic ack_pending
);
    typedef struct packed {
        dwh_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] tout;
        logic ack_en;
        logic pend;
        dwh_kind_t kind;
        logic ack_rdy;
        logic pin_prev;
        logic abort_p;
        logic sreset_p;
        logic bit_p;
        logic ack_p;
        logic sync_p;
        logic pin_out;
        logic pin_oe_n;
    } dwh_core_t;

    dwh_core_t r_reg;
    dwh_core_t r_next;
    logic pin_s;
    logic tick;
    logic fall;
    logic take_abort;
    dwh_kind_t kind_in;

    dwh_pin_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_async(debug_serial_pin_in),
        .pin_sync(pin_s)
    );

    dwh_ser_div u_div (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    assign kind_in = dwh_kind_t'(cmd_kind);
    assign fall = r_reg.pin_prev & ~pin_s;

    always_comb begin
        r_next = r_reg;
        take_abort = 1'b0;
        r_next.abort_p = 1'b0;
        r_next.sreset_p = 1'b0;
        r_next.bit_p = 1'b0;
        r_next.ack_p = 1'b0;
        r_next.sync_p = 1'b0;
        r_next.pin_prev = pin_s;
        // gap since the last falling edge, in serial cycles
        if (fall) begin
            r_next.tout = '0;
        end else if (tick && r_reg.tout != TIMEOUT_TICKS) begin
            r_next.tout = r_reg.tout + CNT_ONE;
        end
        if (cmd_valid) begin
            case (kind_in)
                KIND_ACK_EN: begin
                    r_next.ack_en = 1'b1;
                    r_next.pend = 1'b1;
                    r_next.kind = kind_in;
                    r_next.ack_rdy = 1'b1;
                end
                KIND_ACK_DIS: begin
                    r_next.ack_en = 1'b0;
                    r_next.pend = 1'b0;
                    r_next.ack_rdy = 1'b0;
                end
                default: begin
                    r_next.pend = r_reg.ack_en;
                    r_next.kind = kind_in;
                    r_next.ack_rdy = 1'b0;
                end
            endcase
        end else if (r_reg.pend && !r_reg.ack_rdy) begin
            case (r_reg.kind)
                KIND_READ, KIND_WRITE: r_next.ack_rdy = mem_done;
                KIND_RESUME: r_next.ack_rdy = cpu_exit_bg;
                KIND_HALT, KIND_RUN_HALT, KIND_STEP: begin
                    r_next.ack_rdy = cpu_enter_bg;
                end
                default: r_next.ack_rdy = 1'b0;
            endcase
        end
        case (r_reg.st)
            ST_IDLE: begin
                if (fall) begin
                    r_next.st = ST_LOW_MEAS;
                    r_next.cnt = '0;
                    // an aborting edge is not a command bit
                    take_abort = r_reg.pend;
                    r_next.bit_p = ~r_reg.pend;
                end else if (r_reg.pend && r_reg.ack_rdy && tick) begin
                    r_next.st = ST_ACK_LOW;
                    r_next.cnt = '0;
                    r_next.ack_p = 1'b1;
                    // a command taken this cycle stays pending for its own ack
                    if (!cmd_valid) begin
                        r_next.pend = 1'b0;
                        r_next.ack_rdy = 1'b0;
                    end
                end else if (xfer_partial && r_reg.tout == TIMEOUT_TICKS) begin
                    r_next.sreset_p = 1'b1;
                    r_next.tout = '0;
                end
            end
            ST_LOW_MEAS: begin
                if (pin_s) begin
                    r_next.st = ST_IDLE;
                end else if (tick) begin
                    if (r_reg.cnt == SYNC_THRESH_TICKS) begin
                        r_next.st = ST_WAIT_HIGH;
                        r_next.sync_p = 1'b1;
                        r_next.sreset_p = 1'b1;
                        take_abort = r_reg.pend;
                    end else begin
                        r_next.cnt = r_reg.cnt + CNT_ONE;
                    end
                end
            end
            ST_WAIT_HIGH: begin
                // no timeout here: a stuck low pin waits forever
                if (pin_s) begin
                    r_next.st = ST_SYNC_DELAY;
                    r_next.cnt = '0;
                end
            end
            ST_SYNC_DELAY: begin
                if (tick) begin
                    if (r_reg.cnt == SYNC_DELAY_TICKS - CNT_ONE) begin
                        r_next.st = ST_SYNC_LOW;
                        r_next.cnt = '0;
                    end else begin
                        r_next.cnt = r_reg.cnt + CNT_ONE;
                    end
                end
            end
            ST_SYNC_LOW: begin
                if (tick) begin
                    if (r_reg.cnt == SYNC_LOW_TICKS - CNT_ONE) begin
                        r_next.st = ST_SYNC_SPEED;
                        r_next.cnt = '0;
                    end else begin
                        r_next.cnt = r_reg.cnt + CNT_ONE;
                    end
                end
            end
            ST_ACK_LOW: begin
                if (tick) begin
                    if (r_reg.cnt == ACK_LOW_TICKS - CNT_ONE) begin
                        r_next.st = ST_ACK_SPEED;
                        r_next.cnt = '0;
                    end else begin
                        r_next.cnt = r_reg.cnt + CNT_ONE;
                    end
                end
            end
            ST_SYNC_SPEED, ST_ACK_SPEED: begin
                if (tick) begin
                    r_next.st = ST_IDLE;
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
        if (take_abort) begin
            r_next.pend = 1'b0;
            r_next.ack_rdy = 1'b0;
            r_next.sreset_p = 1'b1;
            // running access finishes; resume, run-halt and step cannot be recalled
            r_next.abort_p = !mem_busy && (r_reg.kind == KIND_READ
                || r_reg.kind == KIND_WRITE || r_reg.kind == KIND_HALT);
        end
        r_next.pin_out = (r_next.st == ST_SYNC_SPEED) || (r_next.st == ST_ACK_SPEED);
        r_next.pin_oe_n = !((r_next.st == ST_SYNC_LOW) || (r_next.st == ST_ACK_LOW)
            || r_next.pin_out);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= '{st: ST_IDLE, kind: KIND_READ, pin_prev: PIN_IDLE,
                pin_oe_n: 1'b1, cnt: '0, tout: '0, ack_en: 1'b0, pend: 1'b0,
                ack_rdy: 1'b0, abort_p: 1'b0, sreset_p: 1'b0, bit_p: 1'b0,
                ack_p: 1'b0, sync_p: 1'b0, pin_out: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign debug_serial_pin_out = r_reg.pin_out;
    assign debug_serial_pin_oe_n = r_reg.pin_oe_n;
    assign abort_cmd = r_reg.abort_p;
    assign soft_reset = r_reg.sreset_p;
    assign bit_start = r_reg.bit_p;
    assign sync_seen = r_reg.sync_p;
    assign ack_sent = r_reg.ack_p;
    assign ack_enabled = r_reg.ack_en;
    assign ack_pending = r_reg.pend;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_speed_tick;
        (!debug_serial_pin_oe_n && debug_serial_pin_out) [*8];
    endsequence
    sequence s_release;
        debug_serial_pin_oe_n;
    endsequence

    property p_reset_disabled;
        !$past(rst_n) |-> !ack_enabled;
    endproperty
    a_reset_disabled: assert property (p_reset_disabled) else $error("handshake on after reset");
    property p_ack_enable;
        cmd_valid && kind_in == KIND_ACK_EN && !(fall && r_reg.st == ST_IDLE && ack_pending)
            |=> ack_enabled && ack_pending;
    endproperty
    a_ack_enable: assert property (p_ack_enable) else $error("enable not taken");
    property p_ack_disable;
        cmd_valid && kind_in == KIND_ACK_DIS |=> !ack_enabled && !ack_pending;
    endproperty
    a_ack_disable: assert property (p_ack_disable) else $error("disable not taken");
    property p_ack_low;
        $rose(r_reg.st == ST_ACK_LOW) |-> (!debug_serial_pin_oe_n && !debug_serial_pin_out) [*8];
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack low not driven");
    property p_ack_len;
        r_reg.st == ST_ACK_LOW |-> r_reg.cnt < ACK_LOW_TICKS;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack low too long");
    property p_sync_tail;
        $rose(r_reg.st == ST_SYNC_SPEED) |-> s_speed_tick ##1 s_release;
    endproperty
    a_sync_tail: assert property (p_sync_tail) else $error("sync speedup wrong");
    property p_sync_len;
        r_reg.st == ST_SYNC_LOW |-> r_reg.cnt < SYNC_LOW_TICKS && !debug_serial_pin_oe_n;
    endproperty
    a_sync_len: assert property (p_sync_len) else $error("sync low wrong");
    property p_release;
        !debug_serial_pin_oe_n |-> r_reg.st inside {ST_SYNC_LOW, ST_SYNC_SPEED,
            ST_ACK_LOW, ST_ACK_SPEED};
    endproperty
    a_release: assert property (p_release) else $error("pin driven out of phase");
    property p_short_abort;
        r_reg.st == ST_IDLE && fall && ack_pending && !cmd_valid
            |=> !ack_pending && soft_reset && !bit_start;
    endproperty
    a_short_abort: assert property (p_short_abort) else $error("edge did not abort");
    property p_abort_busy;
        abort_cmd |-> !$past(mem_busy);
    endproperty
    a_abort_busy: assert property (p_abort_busy) else $error("running access aborted");
    property p_sync_detect;
        $rose(r_reg.st == ST_WAIT_HIGH) |-> sync_seen && soft_reset
            && $past(r_reg.cnt) == SYNC_THRESH_TICKS;
    endproperty
    a_sync_detect: assert property (p_sync_detect) else $error("sync threshold wrong");
    property p_timeout;
        r_reg.tout <= TIMEOUT_TICKS;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout counter overran");
endmodule : dwh_top
`default_nettype wire

// ===== tb_debug_wire_handshake_sync.sv
// testbench of the debug wire handshake block against a probe model
`default_nettype none
module tb_debug_wire_handshake_sync;
    timeunit 1ns;
    timeprecision 1ps;
    import dwh_pkg::*;
    logic clk = 1'b0;
    logic rst_n, cmd_valid, mem_busy, mem_done, cpu_enter_bg, cpu_exit_bg, xfer_partial;
    logic [2:0] cmd_kind;
    logic pin_out, oe_n, abort_cmd, soft_reset, bit_start, sync_seen, ack_sent;
    logic ack_enabled, ack_pending, drv_low, drv_high;
    wire logic pin;
    int low_len, cyc, err_count, checks;
    int cnt [5];
    // pull-up wins only where nobody drives
    assign pin = drv_low ? 1'b0 : (drv_high ? 1'b1 : (oe_n ? 1'b1 : pin_out));
    always #5 clk = ~clk;
    dwh_top DUT (.clk(clk), .rst_n(rst_n), .debug_serial_pin_in(pin),
        .debug_serial_pin_out(pin_out), .debug_serial_pin_oe_n(oe_n),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .mem_busy(mem_busy),
        .mem_done(mem_done), .cpu_enter_bg(cpu_enter_bg), .cpu_exit_bg(cpu_exit_bg),
        .xfer_partial(xfer_partial), .abort_cmd(abort_cmd), .soft_reset(soft_reset),
        .bit_start(bit_start), .sync_seen(sync_seen), .ack_sent(ack_sent),
        .ack_enabled(ack_enabled), .ack_pending(ack_pending));
    dwh_probe probe (.clk(clk), .pin(pin), .drv_low(drv_low), .drv_high(drv_high),
        .low_len(low_len));
    // pulse counters: ack, abort, sync, soft reset, bit start
    always @(posedge clk) begin
        logic [4:0] p;
        p = {bit_start, soft_reset, sync_seen, abort_cmd, ack_sent};
        for (int i = 0; i < 5; i++) begin
            if (p[i] === 1'b1) cnt[i]++;
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    // expected pulse counts, -1 leaves one out
    task automatic chk_cnt(input int e [5]);
        for (int i = 0; i < 5; i++) begin
            if (e[i] >= 0) chk(cnt[i], e[i], $sformatf("pulse count %0d", i));
        end
    endtask : chk_cnt
    task automatic clr;
        foreach (cnt[i]) cnt[i] = 0;
    endtask : clr
    // levels from the memory side and the command shifter
    task automatic set_side(input logic busy, input logic partial);
        mem_busy = busy;
        xfer_partial = partial;
    endtask : set_side
    task automatic drive_reset(input int n);
        rst_n = 1'b0;
        repeat (n) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask : drive_reset
    task automatic issue(input logic [2:0] k);
        cmd_kind = k;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        @(negedge clk);
    endtask : issue
    task automatic fire(input int t);
        mem_done = (t == 0);
        cpu_enter_bg = (t == 1);
        cpu_exit_bg = (t == 2);
        @(negedge clk);
        {mem_done, cpu_enter_bg, cpu_exit_bg} = 3'h0;
    endtask : fire
    // ack start is bounded by one serial tick; then its fixed length
    task automatic wait_ack;
        int n;
        n = 0;
        while (ack_sent !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        repeat (140) @(negedge clk);
    endtask : wait_ack
    task automatic t_reset;
        chk(ack_enabled, 1'b0, "enabled after reset");
        chk(oe_n, 1'b1, "pin released after reset");
        clr();
        issue(KIND_READ);
        fire(0);
        repeat (30) @(negedge clk);
        chk(ack_pending, 1'b0, "pending while disabled");
        chk_cnt('{0, -1, -1, -1, -1});
    endtask : t_reset
    task automatic t_enable;
        clr();
        issue(KIND_ACK_EN);
        wait_ack();
        chk(ack_enabled, 1'b1, "enable");
        chk_cnt('{1, 0, 0, 0, 0});
        chk(low_len, 128, "ack low length");
        chk(oe_n, 1'b1, "released after ack");
    endtask : t_enable
    task automatic t_kinds;
        dwh_kind_t k [6] = '{KIND_READ, KIND_WRITE, KIND_HALT, KIND_RESUME, KIND_RUN_HALT,
            KIND_STEP};
        int trig [6] = '{0, 0, 1, 2, 1, 1};
        for (int i = 0; i < 6; i++) begin
            clr();
            issue(k[i]);
            repeat (24) @(negedge clk);
            chk(ack_pending, 1'b1, "pending before trigger");
            chk_cnt('{0, 0, 0, 0, 0});
            fire(trig[i]);
            wait_ack();
            chk_cnt('{1, 0, 0, 0, 0});
            chk(ack_pending, 1'b0, "pending after ack");
            chk(low_len, 128, "ack low length");
        end
    endtask : t_kinds
    task automatic t_long_abort;
        issue(KIND_READ);
        clr();
        probe.pulse(1040);
        repeat (1300) @(negedge clk);
        chk_cnt('{0, 1, 1, 2, 0});
        chk(ack_pending, 1'b0, "pending after sync");
        chk(low_len, 1024, "sync reply low length");
        chk(oe_n, 1'b1, "released after reply");
        fire(0);
        probe.pulse(32);
        repeat (40) @(negedge clk);
        chk_cnt('{0, 1, 1, 2, 1});
    endtask : t_long_abort
    task automatic t_keep_cmd;
        issue(KIND_READ);
        set_side(1'b1, 1'b0);
        clr();
        probe.pulse(32);
        repeat (20) @(negedge clk);
        set_side(1'b0, 1'b0);
        fire(0);
        issue(KIND_RESUME);
        probe.pulse(32);
        repeat (20) @(negedge clk);
        chk(ack_pending, 1'b0, "pending after abort");
        fire(2);
        repeat (30) @(negedge clk);
        chk_cnt('{0, 0, 0, 2, 0});
    endtask : t_keep_cmd
    task automatic t_short_abort;
        issue(KIND_WRITE);
        clr();
        probe.pulse(32);
        repeat (40) @(negedge clk);
        chk_cnt('{0, 1, 0, 1, 0});
        chk(ack_pending, 1'b0, "pending after short abort");
        probe.pulse(32);
        repeat (40) @(negedge clk);
        chk_cnt('{0, 1, 0, 1, 1});
    endtask : t_short_abort
    task automatic t_timeout;
        set_side(1'b0, 1'b1);
        clr();
        probe.pulse(32);
        repeat (4000) @(negedge clk);
        chk_cnt('{0, 0, 0, 0, 1});
        repeat (200) @(negedge clk);
        chk_cnt('{0, 0, 0, 1, 1});
        set_side(1'b0, 1'b0);
    endtask : t_timeout
    task automatic t_disable;
        issue(KIND_ACK_DIS);
        chk(ack_enabled, 1'b0, "disable");
        clr();
        issue(KIND_WRITE);
        fire(0);
        repeat (30) @(negedge clk);
        chk_cnt('{0, -1, -1, -1, -1});
    endtask : t_disable
    // reset in mid-run with the handshake on and a command pending
    task automatic t_mid_reset;
        issue(KIND_ACK_EN);
        wait_ack();
        issue(KIND_READ);
        chk(ack_pending, 1'b1, "pending before reset");
        drive_reset(2);
        chk(ack_enabled, 1'b0, "enabled after mid reset");
        chk(ack_pending, 1'b0, "pending after mid reset");
        chk(oe_n, 1'b1, "pin released after mid reset");
        clr();
        fire(0);
        issue(KIND_HALT);
        fire(1);
        repeat (30) @(negedge clk);
        chk_cnt('{0, 0, 0, 0, 0});
    endtask : t_mid_reset
    initial begin
        cmd_valid = 1'b0;
        cmd_kind = 3'h0;
        {mem_done, cpu_enter_bg, cpu_exit_bg} = 3'h0;
        set_side(1'b0, 1'b0);
        drive_reset(10);
        t_reset();
        t_enable();
        t_kinds();
        t_long_abort();
        t_keep_cmd();
        t_short_abort();
        t_timeout();
        t_disable();
        t_mid_reset();
        wrap_up();
    end
endmodule : tb_debug_wire_handshake_sync
`default_nettype wire
